/* verilog/converter_input_and_result_format.sv */
// converter input control and result formatting, an APB slave
// assumes a single 40 MHz clock, synchronous inputs and an analog core
// that answers each start pulse with a done pulse and a result word
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

`include "converter_defines.svh"

// How it works
// - with reference select clear the supply is the reference, set picks the internal one.
// - differential enable picks differential mode when set, single-ended when clear.
// - input hold keeps the selected inputs connected to the converter while set and converter enable is set.
// - single-ended code 110 takes the temperature sensor with reference select set, else supply/8.
// - right adjust puts result bits 7..0 into low result bits 7..0.
// - left adjust puts result bits 1..0 into low result bits 7..6 with 5..0 zero.
// - right adjust puts result bits 9..8 into high bits 1..0, sign extended above.
// - left adjust puts result bits 9..2 into high result bits 7..0.
// - with a timer trigger every overflow of that timer while idle, enabled and on a non-reserved channel code starts a conversion.
// - with a hardware trigger the device sets busy while a conversion runs.
// - converter enable switches the whole converter on when set and off when clear.
module converter_input_and_result_format #(
    parameter int RESULT_WIDTH   = 10,
    parameter int CONVERT_CYCLES = `CONVERT_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      clk_en,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // timer overflow pulses
    input  wire logic                      timer0_overflow,
    input  wire logic                      timer1_overflow,
    input  wire logic                      timer2_overflow,
    // converter core
    input  wire logic                      core_done,
    input  wire logic [RESULT_WIDTH-1:0]   core_result,
    output logic                           core_start,
    output logic                           converter_on,
    output logic                           use_internal_ref,
    output logic                           differential_mode,
    output logic                           input_hold,
    output converter_pkg::pos_input_t      pos_sel,
    output converter_pkg::neg_input_t      neg_sel,
    output logic                           busy
);
    import converter_pkg::*;

    typedef struct packed {
        logic [7:0]              input_control;
        logic                    enable;
        logic                    left_adjust;
        logic                    go_busy;
        conv_state_t             state;
        logic [15:0]             timer;
        logic [RESULT_WIDTH-1:0] result;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic                    core_start;
        logic                    converter_on;
        logic                    use_internal_ref;
        logic                    differential_mode;
        logic                    input_hold;
        pos_input_t              pos_sel;
        neg_input_t              neg_sel;
    } regs_t;

    regs_t r;
    regs_t next_r;

    logic [7:0] fmt_low;
    logic [7:0] fmt_high;
    pos_input_t dec_pos;
    neg_input_t dec_neg;
    logic       dec_reserved;
    logic       apb_access;
    logic       apb_write;
    logic       trigger_hit;
    trigger_t   trig;

    // read value of the control register
    function automatic logic [7:0] ctrl_byte(input logic go, input logic en, input logic la);
        logic [7:0] b;
        b                   = `RESET_BYTE;
        b[`BIT_GO_BUSY]     = go;
        b[`BIT_ENABLE]      = en;
        b[`BIT_LEFT_ADJUST] = la;
        return b;
    endfunction

    channel_decode u_decode (
        .differential_enable (r.input_control[`BIT_DIFFERENTIAL_ENABLE]),
        .reference_select    (r.input_control[`BIT_REF]),
        .channel_select      (r.input_control[`BIT_CHAN_HI:0]),
        .pos_sel             (dec_pos),
        .neg_sel             (dec_neg),
        .reserved_code       (dec_reserved)
    );

    result_format #(
        .RESULT_WIDTH (RESULT_WIDTH)
    ) u_format (
        .result      (r.result),
        .left_adjust (r.left_adjust),
        .low_byte    (fmt_low),
        .high_byte   (fmt_high)
    );

    // apb access phase, taken in the first access cycle, pready answers in the second
    assign apb_access = psel && penable && !r.pready;
    assign apb_write  = apb_access && pwrite;
    assign trig       = trigger_t'(r.input_control[`BIT_TRG_HI:`BIT_TRG_LO]);

    // selected timer overflow
    always_comb begin
        unique case (trig)
            trig_software: trigger_hit = 1'b0;
            trig_timer0:   trigger_hit = timer0_overflow;
            trig_timer1:   trigger_hit = timer1_overflow;
            trig_timer2:   trigger_hit = timer2_overflow;
        endcase
    end

    // next state of the whole block
    always_comb begin
        next_r            = r;
        next_r.pready     = 1'b0;
        next_r.pslverr    = 1'b0;
        next_r.core_start = 1'b0;
        // register writes
        if (apb_write) begin
            unique case (paddr)
                `ADDR_INPUT_CONTROL: next_r.input_control = pwdata[7:0];
                `ADDR_CONVERTER_CTRL: begin
                    next_r.enable      = pwdata[`BIT_ENABLE];
                    next_r.left_adjust = pwdata[`BIT_LEFT_ADJUST];
                end
                `ADDR_RESULT_LOW, `ADDR_RESULT_HIGH: ;
                default: next_r.pslverr = 1'b1;
            endcase
        end
        // register reads
        if (apb_access) begin
            next_r.pready = 1'b1;
            unique case (paddr)
                `ADDR_INPUT_CONTROL:  next_r.prdata = {24'h000000, r.input_control};
                `ADDR_CONVERTER_CTRL: next_r.prdata = {24'h000000,
                                          ctrl_byte(r.go_busy, r.enable, r.left_adjust)};
                `ADDR_RESULT_LOW:     next_r.prdata = {24'h000000, fmt_low};
                `ADDR_RESULT_HIGH:    next_r.prdata = {24'h000000, fmt_high};
                default: begin
                    next_r.prdata  = 32'h00000000;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        // conversion sequencing
        unique case (r.state)
            st_idle: begin
                if (r.enable && !dec_reserved) begin
                    if ((trig == trig_software && apb_write
                         && paddr == `ADDR_CONVERTER_CTRL && pwdata[`BIT_GO_BUSY])
                        || trigger_hit) begin
                        next_r.state      = st_busy;
                        next_r.go_busy    = 1'b1;
                        next_r.core_start = 1'b1;
                        next_r.timer      = 16'(CONVERT_CYCLES);
                    end
                end
            end
            st_busy: begin
                if (r.timer != 16'h0000) begin
                    next_r.timer = r.timer - 16'h0001;
                end
                if (core_done || r.timer == 16'h0000) begin
                    next_r.state   = st_idle;
                    next_r.go_busy = 1'b0;
                    if (core_done) begin
                        next_r.result = core_result;
                    end
                end
            end
            default: next_r.state = st_idle;
        endcase
        // disabling aborts a running conversion
        if (!r.enable) begin
            next_r.state   = st_idle;
            next_r.go_busy = 1'b0;
        end
        // analog side controls
        next_r.converter_on      = r.enable;
        next_r.use_internal_ref  = r.input_control[`BIT_REF];
        next_r.differential_mode = r.input_control[`BIT_DIFFERENTIAL_ENABLE];
        next_r.input_hold        = r.enable && r.input_control[`BIT_HOLD];
        next_r.pos_sel           = dec_pos;
        next_r.neg_sel           = dec_neg;
    end

    // state register with clock enable
    always_ff @(posedge clk) begin
        if (rst) begin
            r          <= '0;
            r.pos_sel  <= pos_pin0;
            r.neg_sel  <= neg_vdd_half;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // outputs straight from flip-flops
    assign prdata            = r.prdata;
    assign pready            = r.pready;
    assign pslverr           = r.pslverr;
    assign core_start        = r.core_start;
    assign converter_on      = r.converter_on;
    assign use_internal_ref  = r.use_internal_ref;
    assign differential_mode = r.differential_mode;
    assign input_hold        = r.input_hold;
    assign pos_sel           = r.pos_sel;
    assign neg_sel           = r.neg_sel;
    assign busy              = r.go_busy;

endmodule

`default_nettype wire

/* pkg/converter_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from package and design files
`ifndef CONVERTER_DEFINES_SVH
`define CONVERTER_DEFINES_SVH

// register byte addresses, printed offsets are multiples of four times index
`define OFS_INPUT_CONTROL   8'ha5
`define OFS_RESULT_LOW      8'hac
`define OFS_RESULT_HIGH     8'had
`define OFS_CONVERTER_CTRL  8'ha4
`define ADDR_INPUT_CONTROL  12'h294
`define ADDR_RESULT_LOW     12'h2b0
`define ADDR_RESULT_HIGH    12'h2b4
`define ADDR_CONVERTER_CTRL 12'h290

// input control fields
`define BIT_HOLD            7
`define BIT_REF             6
`define BIT_TRG_HI          5
`define BIT_TRG_LO          4
`define BIT_DIFFERENTIAL_ENABLE            3
`define BIT_CHAN_HI         2
// control register fields
`define BIT_GO_BUSY         6
`define BIT_ENABLE          4
`define BIT_LEFT_ADJUST     3

`define RESET_BYTE          8'h00

// conversion time in ns and its cycle count at 40 MHz (25 ns)
`define CONVERT_TIME_NS     3250
`define CLK_PERIOD_NS       25
`define CONVERT_CYCLES      ((`CONVERT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* pkg/converter_pkg.sv */
// types shared by the converter control files
// assumes nothing of its surroundings
package converter_pkg;

    typedef enum logic [1:0] {
        trig_software = 2'b00,
        trig_timer0   = 2'b01,
        trig_timer1   = 2'b10,
        trig_timer2   = 2'b11
    } trigger_t;

    // positive input choice for the analog mux
    typedef enum logic [3:0] {
        pos_pin0      = 4'h0,
        pos_pin1      = 4'h1,
        pos_pin2      = 4'h2,
        pos_pin3      = 4'h3,
        pos_pin4      = 4'h4,
        pos_pin5      = 4'h5,
        pos_pin6      = 4'h6,
        pos_temp      = 4'h7,
        pos_vdd_div8  = 4'h8,
        pos_none      = 4'hf
    } pos_input_t;

    // negative input choice for the analog mux
    typedef enum logic [2:0] {
        neg_vdd_half  = 3'h0,
        neg_vref      = 3'h1,
        neg_pin1      = 3'h2,
        neg_pin3      = 3'h3,
        neg_pin5      = 3'h4,
        neg_none      = 3'h7
    } neg_input_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_busy = 2'b01
    } conv_state_t;

endpackage

/* verilog/channel_decode.sv */
// decodes channel select, mode and reference into analog mux choices
// assumes registered inputs, purely combinational
`timescale 1ns/10ps
`default_nettype none

module channel_decode (
    input  wire logic                    differential_enable,
    input  wire logic                    reference_select,
    input  wire logic [2:0]              channel_select,
    output var  converter_pkg::pos_input_t pos_sel,
    output var  converter_pkg::neg_input_t neg_sel,
    output var  logic                    reserved_code
);
    import converter_pkg::*;

    // single-ended or differential table
    always_comb begin
        pos_sel       = pos_none;
        neg_sel       = neg_none;
        reserved_code = 1'b0;
        if (!differential_enable) begin
            neg_sel = neg_vdd_half;
            unique case (channel_select)
                3'h0: pos_sel = pos_pin0;
                3'h1: pos_sel = pos_pin1;
                3'h2: pos_sel = pos_pin2;
                3'h3: pos_sel = pos_pin3;
                3'h4: pos_sel = pos_pin4;
                3'h5: pos_sel = pos_pin5;
                3'h6: begin
                    pos_sel = reference_select ? pos_temp : pos_vdd_div8;
                    neg_sel = neg_vref;
                end
                3'h7: pos_sel = pos_pin6;
            endcase
        end else begin
            unique case (channel_select)
                3'h0: begin
                    pos_sel = pos_pin0;
                    neg_sel = neg_pin1;
                end
                3'h1: begin
                    pos_sel = pos_pin2;
                    neg_sel = neg_pin3;
                end
                3'h2: begin
                    pos_sel = pos_pin4;
                    neg_sel = neg_pin5;
                end
                default: reserved_code = 1'b1;
            endcase
        end
    end

endmodule

`default_nettype wire

/* verilog/result_format.sv */
// places a 10-bit result into the low and high result bytes
// assumes a stable result word, purely combinational
`timescale 1ns/10ps
`default_nettype none

module result_format #(
    parameter int RESULT_WIDTH = 10
) (
    input  wire logic [RESULT_WIDTH-1:0] result,
    input  wire logic                    left_adjust,
    output var  logic [7:0]              low_byte,
    output var  logic [7:0]              high_byte
);

    // right justified with sign extension, or left justified
    always_comb begin
        if (left_adjust) begin
            low_byte  = {result[1:0], 6'h00};
            high_byte = result[9:2];
        end else begin
            low_byte  = result[7:0];
            high_byte = {{6{result[9]}}, result[9:8]};
        end
    end

endmodule

`default_nettype wire

/* sim/converter_core_model.sv */
// behavioural model of the converter core on the far side of the block
// assumes a start pulse from the block and a result value set by the bench
`timescale 1ns/10ps
`default_nettype none

module converter_core_model #(
    parameter int LATENCY = 4
) (
    input  wire logic       clk,
    input  wire logic       core_start,
    input  wire logic [9:0] value,
    output logic            core_done,
    output logic [9:0]      core_result
);
    int         cnt = 0;
    logic [9:0] held = 10'h000;

    initial core_done = 1'b0;

    // count down from start, then one done pulse with the result
    always @(posedge clk) begin
        core_done <= 1'b0;
        if (core_start) begin
            cnt <= LATENCY;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            core_done <= 1'b1;
            held <= value;
        end
    end

    // result is only valid with done, garbage otherwise
    assign core_result = core_done ? held : ~held;
endmodule
`default_nettype wire

/* sim/converter_input_and_result_format_asserts.sv */
// concurrent checks on the converter control ports
// assumes binding to the top module, clock enable held high
`timescale 1ns/10ps
`default_nettype none
`include "converter_defines.svh"

module converter_input_and_result_format_asserts
    import converter_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        core_start,
    input wire logic        core_done,
    input wire logic        busy,
    input wire logic        converter_on,
    input wire logic        use_internal_ref,
    input wire logic        differential_mode,
    input wire logic        input_hold,
    input wire pos_input_t  pos_sel,
    input wire neg_input_t  neg_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // single-ended positive input for a code
    function automatic pos_input_t se_pos(logic [2:0] c);
        return pos_input_t'({1'b0, (c == 3'h7) ? 3'h6 : c});
    endfunction

    // write accesses taken at their access edge
    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && !pready && paddr == a;
    endsequence

    chk_ref_follow:
    assert property (s_wr(`ADDR_INPUT_CONTROL) |-> ##2 use_internal_ref == $past(pwdata[6], 2))
        else $error("reference select not applied");
    chk_differential_enable_follow:
    assert property (s_wr(`ADDR_INPUT_CONTROL) |-> ##2 differential_mode == $past(pwdata[3], 2))
        else $error("differential mode not applied");
    chk_hold_follow:
    assert property (s_wr(`ADDR_INPUT_CONTROL) |-> ##2
                     input_hold == ($past(pwdata[7], 2) && converter_on))
        else $error("input hold wrong");
    chk_temp_input:
    assert property (s_wr(`ADDR_INPUT_CONTROL) && pwdata[3:0] == 4'h6 |-> ##2
                     pos_sel == ($past(pwdata[6], 2) ? pos_temp : pos_vdd_div8))
        else $error("temperature input wrong");
    chk_single_chan:
    assert property (s_wr(`ADDR_INPUT_CONTROL) && !pwdata[3] && pwdata[2:0] != 3'h6 |-> ##2
                     pos_sel == se_pos($past(pwdata[2:0], 2)) && neg_sel == neg_vdd_half)
        else $error("single-ended channel wrong");
    chk_differential_enable_pair:
    assert property (s_wr(`ADDR_INPUT_CONTROL) && pwdata[3:0] == 4'h8 |-> ##2
                     pos_sel == pos_pin0 && neg_sel == neg_pin1)
        else $error("differential pair wrong");
    chk_enable_follow:
    assert property (s_wr(`ADDR_CONVERTER_CTRL) |-> ##2 converter_on == $past(pwdata[4], 2))
        else $error("enable not applied");
    chk_start_pulse:
    assert property (core_start |=> !core_start)
        else $error("start longer than one cycle");
    chk_start_busy:
    assert property ($rose(busy) |-> core_start)
        else $error("busy without start");
    chk_done_idle:
    assert property (busy && core_done |=> !busy)
        else $error("busy held after done");
endmodule
`default_nettype wire

/* sim/test_converter_input_and_result_format.sv */
// self-checking bench for converter input control and result format
// assumes the design, its package and the core model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "converter_defines.svh"

module test_converter_input_and_result_format;
    import converter_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, core_start, core_done, busy;
    logic        converter_on, use_internal_ref, differential_mode, input_hold;
    logic [2:0]  tov = '0;
    logic [9:0]  value = '0, core_result, v;
    pos_input_t  pos_sel;
    neg_input_t  neg_sel;
    int          bad_count = 0, check_count = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    converter_input_and_result_format #(.CONVERT_CYCLES(8)) DUT (
        .clk, .rst, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .timer0_overflow(tov[0]),
        .timer1_overflow(tov[1]), .timer2_overflow(tov[2]), .core_done,
        .core_result, .core_start, .converter_on, .use_internal_ref,
        .differential_mode, .input_hold, .pos_sel, .neg_sel, .busy);

    converter_core_model #(.LATENCY(4)) core (
        .clk, .core_start, .value, .core_done, .core_result);

    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin bad_count++; print_verdict; end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 8'h00);
        check(rd, exp);
    endtask

    // bounded wait for the conversion to finish
    task wait_idle;
        int n;
        for (n = 0; n < 50 && busy !== 1'b0; n++) @(posedge clk);
        if (busy !== 1'b0) begin bad_count++; print_verdict; end
    endtask

    task pulse(input int t);
        @(posedge clk);
        tov[t] <= 1'b1;
        @(posedge clk);
        tov <= 3'h0;
        @(posedge clk);
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`ADDR_INPUT_CONTROL, 32'h0);
        rd_chk(`ADDR_RESULT_LOW, 32'h0);
        rd_chk(`ADDR_RESULT_HIGH, 32'h0);
        apb(12'h2f0, 1'b0, 8'h00);
        check({31'h0, err}, 32'h1);
        apb(`ADDR_RESULT_LOW, 1'b1, 8'h5a);
        rd_chk(`ADDR_RESULT_LOW, 32'h0);
        apb(`ADDR_CONVERTER_CTRL, 1'b1, 8'h10);
        @(posedge clk);
        check({31'h0, converter_on}, 32'h1);
        // every channel code in both modes with both references
        for (int i = 0; i < 32; i++) begin
            apb(`ADDR_INPUT_CONTROL, 1'b1, {i[0], i[4], 2'b00, i[3:0]});
            @(posedge clk);
            check({30'h0, differential_mode, use_internal_ref}, {30'h0, i[3], i[4]});
            check({31'h0, input_hold}, {31'h0, i[0]});
        end
        rd_chk(`ADDR_INPUT_CONTROL, 32'hcf);
        for (int r = 0; r < 2; r++) begin
            apb(`ADDR_INPUT_CONTROL, 1'b1, {1'b0, r[0], 6'h06});
            @(posedge clk);
            check({28'h0, pos_sel}, {28'h0, r ? pos_temp : pos_vdd_div8});
        end
        // software conversions, negative and positive results
        apb(`ADDR_INPUT_CONTROL, 1'b1, 8'h00);
        for (int k = 0; k < 2; k++) begin
            v = k ? 10'h1c5 : 10'h2c5;
            value <= v;
            apb(`ADDR_CONVERTER_CTRL, 1'b1, 8'h50);
            @(posedge clk);
            check({31'h0, busy}, 32'h1);
            wait_idle;
            rd_chk(`ADDR_RESULT_LOW, {24'h0, v[7:0]});
            rd_chk(`ADDR_RESULT_HIGH, {24'h0, {6{v[9]}}, v[9:8]});
            apb(`ADDR_CONVERTER_CTRL, 1'b1, 8'h18);
            rd_chk(`ADDR_RESULT_LOW, {24'h0, v[1:0], 6'h0});
            rd_chk(`ADDR_RESULT_HIGH, {24'h0, v[9:2]});
        end
        // each timer trigger, with a wrong timer first
        for (int t = 1; t < 4; t++) begin
            apb(`ADDR_INPUT_CONTROL, 1'b1, {2'b00, t[1:0], 4'h0});
            pulse(t % 3);
            check({31'h0, busy}, 32'h0);
            pulse(t - 1);
            check({31'h0, busy}, 32'h1);
            wait_idle;
        end
        // a reserved differential code must not start a conversion
        apb(`ADDR_INPUT_CONTROL, 1'b1, 8'h0b);
        apb(`ADDR_CONVERTER_CTRL, 1'b1, 8'h50);
        @(posedge clk);
        check({31'h0, busy}, 32'h0);
        apb(`ADDR_CONVERTER_CTRL, 1'b1, 8'h00);
        @(posedge clk);
        check({31'h0, converter_on}, 32'h0);
        print_verdict;
    end
endmodule

bind converter_input_and_result_format converter_input_and_result_format_asserts chk (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .core_start,
    .core_done, .busy, .converter_on, .use_internal_ref, .differential_mode,
    .input_hold, .pos_sel, .neg_sel);
`default_nettype wire
